// ===== hdl/iaul_pkg.sv
/*
  Constants for the integer add and logic unit: register offsets, field
  positions, reset values, opcode encodings and the decoded operation type.
  Assumes a 32-bit little-endian bit numbering for instruction fields.
*/
package iaul_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_INSTR = 8'h00;
  localparam logic [7:0]  OFS_EXC   = 8'h04;
  localparam logic [7:0]  OFS_CR    = 8'h08;
  localparam logic [7:0]  OFS_STAT  = 8'h0c;
  localparam int          GPR_SEL_BIT = 7;    // 0x80..0xfc hold the gprs

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          EXC_STICKY = 31;
  localparam int          EXC_SWRAP  = 30;
  localparam int          EXC_UWRAP  = 29;
  localparam int          STAT_ILL = 0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0]  RST_CR   = 4'h0;

  // ----------------------------------------------------------------
  // opcode encodings
  // ----------------------------------------------------------------
  localparam logic [5:0]  OPC_X      = 6'h1f;
  localparam logic [5:0]  OPC_ADDIC  = 6'h0c;
  localparam logic [5:0]  OPC_ADDICR = 6'h0d;
  localparam logic [5:0]  OPC_ADDI   = 6'h0e;
  localparam logic [5:0]  OPC_ADDIS  = 6'h0f;
  localparam logic [8:0]  XO_ADD     = 9'h10a;
  localparam logic [8:0]  XO_ADDC    = 9'h00a;
  localparam logic [8:0]  XO_ADDE    = 9'h08a;
  localparam logic [8:0]  XO_ADDME   = 9'h0ea;
  localparam logic [8:0]  XO_ADDZE   = 9'h0ca;
  localparam logic [9:0]  XO_AND     = 10'h01c;

  // ----------------------------------------------------------------
  // bus answers and decoded operations
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    OP_ADD, OP_ADDC, OP_ADDE, OP_ADDI, OP_ADDIC, OP_ADDICR,
    OP_ADDIS, OP_ADDME, OP_ADDZE, OP_AND, OP_ILL
  } iaul_op_t;

endpackage

// ===== hdl/iaul_top.sv
/*
  Integer add and logic unit with its gpr file, exception and condition
  state, reached over an AXI4-Lite slave. Writing the instruction register
  executes the word in the same cycle.
  Assumes a single clock domain; all AXI inputs come from logic on clk_sys.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - add writes sum of two registers
// - record bit updates condition field from result
// - overflow enable updates sticky and signed wrap
// - carrying add sets unsigned wrap on carry
// - extended add includes unsigned wrap carry in
// - literal add, zero field means zero
// - carrying literal add sets unsigned wrap
// - carrying literal record always updates condition
// - shifted literal add, upper half literal
// - minus one extended adds all ones
// - zero extended adds carry only
// - and writes bitwise and into second field
// - primary opcode from top six bits
// - bad defined field raises illegal instruction
module iaul_top
  import iaul_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   illegal_instr
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0]       gpr_q [32];
  logic [31:0]       instr_q;
  logic              so_q;
  logic              swrap_q;
  logic              uwrap_q;
  logic [3:0]        cr_q;
  logic              ill_q;
  logic              ill_pulse_q;
  logic              aw_hold_q;
  logic              w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  // ----------------------------------------------------------------
  // write channel handshake
  // ----------------------------------------------------------------
  wire               aw_take = s_axi_awvalid & awready_q;
  wire               w_take  = s_axi_wvalid & wready_q;
  wire               aw_have = aw_hold_q | aw_take;
  wire               w_have  = w_hold_q | w_take;
  wire               do_wr   = aw_have & w_have & ~bvalid_q;
  wire [ADDR_W-1:0]  wa      = aw_take ? s_axi_awaddr : awaddr_q;
  wire [31:0]        wd      = w_take ? s_axi_wdata : wdata_q;
  wire [3:0]         ws      = w_take ? s_axi_wstrb : wstrb_q;
  wire               aw_hold_d = aw_have & ~do_wr;
  wire               w_hold_d  = w_have & ~do_wr;
  wire               bvalid_d  = do_wr | (bvalid_q & ~s_axi_bready);

  // byte lanes expanded to a bit mask
  wire [31:0]        wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};

  // ----------------------------------------------------------------
  // write address decode
  // ----------------------------------------------------------------
  wire               wsel_gpr   = wa[GPR_SEL_BIT] & (wa[1:0] == 2'b00);
  wire [4:0]         wgpr_idx   = wa[6:2];
  wire               wsel_instr = wa == ADDR_W'(OFS_INSTR);
  wire               wsel_exc   = wa == ADDR_W'(OFS_EXC);
  wire               wsel_cr    = wa == ADDR_W'(OFS_CR);
  wire               wsel_stat  = wa == ADDR_W'(OFS_STAT);
  wire               wsel_ok    = wsel_gpr | wsel_instr | wsel_exc | wsel_cr | wsel_stat;
  wire [31:0]        exc_word   = {so_q, swrap_q, uwrap_q, 29'h0};
  wire [31:0]        exc_wr     = (exc_word & ~wmask) | (wd & wmask);
  wire [31:0]        cr_wr      = ({28'h0, cr_q} & ~wmask) | (wd & wmask);
  wire [31:0]        gpr_merge  = (gpr_q[wgpr_idx] & ~wmask) | (wd & wmask);

  // the instruction executes from the merged word, so a partial write
  // re-runs the previous word with the new lanes patched in
  wire [31:0]        iw   = (instr_q & ~wmask) | (wd & wmask);
  wire               exec = do_wr & wsel_instr;

  // ----------------------------------------------------------------
  // instruction fields, bit 31 is the msb
  // ----------------------------------------------------------------
  wire [5:0]         f_opc = iw[31:26];
  wire [4:0]         f_dst  = iw[25:21];
  wire [4:0]         f_src1 = iw[20:16];
  wire [4:0]         f_src2 = iw[15:11];
  wire               f_oe  = iw[10];
  wire [8:0]         f_xo9 = iw[9:1];
  wire [9:0]         f_xo10 = iw[10:1];
  wire               f_rec = iw[0];
  wire [15:0]        f_lit = iw[15:0];

  // ----------------------------------------------------------------
  // operation decode
  // ----------------------------------------------------------------
  iaul_op_t          op;

  always_comb
  begin
    case (f_opc)
      OPC_ADDI:   op = OP_ADDI;
      OPC_ADDIC:  op = OP_ADDIC;
      OPC_ADDICR: op = OP_ADDICR;
      OPC_ADDIS:  op = OP_ADDIS;
      OPC_X:
      begin
        if (f_xo10 == XO_AND)
          op = OP_AND;
        else
        begin
          case (f_xo9)
            XO_ADD:   op = OP_ADD;
            XO_ADDC:  op = OP_ADDC;
            XO_ADDE:  op = OP_ADDE;
            XO_ADDME: op = OP_ADDME;
            XO_ADDZE: op = OP_ADDZE;
            default:  op = OP_ILL;
          endcase
        end
      end
      default:    op = OP_ILL;
    endcase
  end

  // ----------------------------------------------------------------
  // operand selection
  // ----------------------------------------------------------------
  wire               is_and  = op == OP_AND;
  wire               is_ill  = op == OP_ILL;
  wire               is_xadd = (op == OP_ADD) | (op == OP_ADDC) | (op == OP_ADDE) |
                               (op == OP_ADDME) | (op == OP_ADDZE);
  wire               is_slit = (op == OP_ADDI) | (op == OP_ADDIC) | (op == OP_ADDICR);
  wire               a_zero  = ((op == OP_ADDI) | (op == OP_ADDIS)) & (f_src1 == 5'h00);
  wire [4:0]         a_idx   = is_and ? f_dst : f_src1;
  wire [31:0]        opa     = a_zero ? 32'h0 : gpr_q[a_idx];
  wire [31:0]        lit_sx  = {{16{f_lit[15]}}, f_lit};
  wire [31:0]        lit_hi  = {f_lit, 16'h0};
  logic [31:0]       opb;
  logic              cin;

  always_comb
  begin
    opb = gpr_q[f_src2];
    cin = 1'b0;
    if (is_slit)
      opb = lit_sx;
    else if (op == OP_ADDIS)
      opb = lit_hi;
    else if (op == OP_ADDME)
      opb = 32'hffff_ffff;
    else if (op == OP_ADDZE)
      opb = 32'h0;
    if ((op == OP_ADDE) | (op == OP_ADDME) | (op == OP_ADDZE))
      cin = uwrap_q;
  end

  // ----------------------------------------------------------------
  // adder, logic and flag results
  // ----------------------------------------------------------------
  wire [32:0]        sum33  = {1'b0, opa} + {1'b0, opb} + {32'h0, cin};
  wire [31:0]        res    = is_and ? (opa & opb) : sum33[31:0];
  wire [4:0]         dst    = is_and ? f_src1 : f_dst;
  wire               uw_wr  = (op == OP_ADDC) | (op == OP_ADDE) | (op == OP_ADDIC) |
                              (op == OP_ADDICR) | (op == OP_ADDME) | (op == OP_ADDZE);
  wire               sw_wr  = is_xadd & f_oe;
  wire               cr_upd = (op == OP_ADDICR) | ((is_xadd | is_and) & f_rec);
  // two's complement overflow: like-signed inputs, differently signed sum
  wire               sw_new = (opa[31] == opb[31]) & (res[31] != opa[31]);
  wire               so_new = sw_wr ? (so_q | sw_new) : so_q;
  wire [3:0]         cr_new = {res[31], ~res[31] & (|res), res == 32'h0, so_new};
  wire               ex_ok  = exec & ~is_ill;

  // ----------------------------------------------------------------
  // gpr write port, shared by bus and execution
  // ----------------------------------------------------------------
  wire               gpr_we = (do_wr & wsel_gpr) | ex_ok;
  wire [4:0]         gpr_wi = ex_ok ? dst : wgpr_idx;
  wire [31:0]        gpr_wd = ex_ok ? res : gpr_merge;

  // storage is flops; reset clears every entry
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 32; i++)
        gpr_q[i] <= RST_WORD;
    end
    else if (ce & gpr_we)
      gpr_q[gpr_wi] <= gpr_wd;
  end

  // ----------------------------------------------------------------
  // exception, condition and status state
  // ----------------------------------------------------------------
  wire               so_d  = ex_ok ? so_new : (do_wr & wsel_exc) ? exc_wr[EXC_STICKY] : so_q;
  wire               sw_d  = (ex_ok & sw_wr) ? sw_new :
                             (do_wr & wsel_exc) ? exc_wr[EXC_SWRAP] : swrap_q;
  wire               uw_d  = (ex_ok & uw_wr) ? sum33[32] :
                             (do_wr & wsel_exc) ? exc_wr[EXC_UWRAP] : uwrap_q;
  wire [3:0]         cr_d  = (ex_ok & cr_upd) ? cr_new :
                             (do_wr & wsel_cr) ? cr_wr[3:0] : cr_q;
  // a new illegal word wins over a write-one clear in the same cycle
  wire               ill_set = exec & is_ill;
  wire               ill_clr = do_wr & wsel_stat & ws[0] & wd[STAT_ILL];
  wire               ill_d   = ill_set | (ill_q & ~ill_clr);

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      instr_q     <= RST_WORD;
      so_q        <= 1'b0;
      swrap_q     <= 1'b0;
      uwrap_q     <= 1'b0;
      cr_q        <= RST_CR;
      ill_q       <= 1'b0;
      ill_pulse_q <= 1'b0;
    end
    else if (ce)
    begin
      if (exec)
        instr_q <= iw;
      so_q        <= so_d;
      swrap_q     <= sw_d;
      uwrap_q     <= uw_d;
      cr_q        <= cr_d;
      ill_q       <= ill_d;
      ill_pulse_q <= ill_set;
    end
  end

  // ----------------------------------------------------------------
  // write channel registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= RST_WORD;
      wstrb_q   <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end
    else if (ce)
    begin
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      if (aw_take)
        awaddr_q <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      awready_q <= ~aw_hold_d & ~bvalid_d;
      wready_q  <= ~w_hold_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
      if (do_wr)
        bresp_q <= wsel_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  wire               ar_take  = s_axi_arvalid & arready_q;
  wire               rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
  wire               rsel_gpr = s_axi_araddr[GPR_SEL_BIT] & (s_axi_araddr[1:0] == 2'b00);
  wire               rsel_ins = s_axi_araddr == ADDR_W'(OFS_INSTR);
  wire               rsel_exc = s_axi_araddr == ADDR_W'(OFS_EXC);
  wire               rsel_cr  = s_axi_araddr == ADDR_W'(OFS_CR);
  wire               rsel_st  = s_axi_araddr == ADDR_W'(OFS_STAT);
  wire               rsel_ok  = rsel_gpr | rsel_ins | rsel_exc | rsel_cr | rsel_st;
  wire [31:0]        rmux     = rsel_gpr ? gpr_q[s_axi_araddr[6:2]] :
                                rsel_ins ? instr_q :
                                rsel_exc ? exc_word :
                                rsel_cr  ? {28'h0, cr_q} :
                                rsel_st  ? {31'h0, ill_q} : 32'h0;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= RST_WORD;
      rresp_q   <= RESP_OKAY;
    end
    else if (ce)
    begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_take)
      begin
        rdata_q <= rmux;
        rresp_q <= rsel_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign illegal_instr = ill_pulse_q;

endmodule

// ===== verification/iaul_monitor.sv
/*
  Bus and exception checks for the add and logic unit.
  Assumes it sees only the top ports, on clk_sys.
*/
`timescale 1ns/1ps
module iaul_monitor
  import iaul_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        ce,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        illegal_instr
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // answers stand until taken; ce low freezes them as well
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_ar_answer: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_w_answer: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
  a_b_release: assert property (ce && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
  a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("second write accepted");
  a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  a_ill_pulse: assert property (ce && illegal_instr |=> !illegal_instr)
    else $error("illegal flag longer than a cycle");
  a_ill_cause: assert property (illegal_instr |-> s_axi_bvalid
    && s_axi_bresp == RESP_OKAY) else $error("illegal flag without a write");
endmodule

bind iaul_top iaul_monitor mon_u (
  .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .illegal_instr(illegal_instr)
);

// ===== verification/iaul_axi_master.sv
/*
  AXI4-Lite master standing in for the software side.
  Assumes one clock; waits on the slave with no fixed latency.
*/
`timescale 1ns/1ps
module iaul_axi_master (
  input  wire logic        clk_sys,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // idle bus at time zero
  initial
  begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    wstrb = 4'hf;
  end

  // released payload is inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'b111;
    forever
    begin
      @(posedge clk_sys);
      if (bvalid) break;
      if (awready) {awvalid, awaddr} <= {1'b0, ~a};
      if (wready) {wvalid, wdata} <= {1'b0, ~d};
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    {araddr, arvalid, rready} <= {a, 2'b11};
    forever
    begin
      @(posedge clk_sys);
      if (rvalid) break;
      if (arready) {arvalid, araddr} <= {1'b0, ~a};
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// ===== verification/tb_top.sv
/*
  Self-checking bench: executes each add form and the and form.
  Assumes the bound monitor and the master model alongside.
*/
`timescale 1ns/1ps
module tb_top
  import iaul_pkg::*;
;
  logic        clk_sys, rst_b, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, illegal_instr;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  int          n_fail, tests_run, n_ill, cyc;

  iaul_top dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .illegal_instr(illegal_instr));
  iaul_axi_master mst_u (.clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] xw(logic [8:0] xo, logic [4:0] t, a, b, logic o, c);
    return {6'h1f, t, a, b, o, xo, c};
  endfunction

  function automatic logic [31:0] dw(logic [5:0] op, logic [4:0] t, a, logic [15:0] m);
    return {op, t, a, m};
  endfunction

  task automatic pk(input logic [4:0] g, input logic [31:0] d);
    mst_u.wr({1'b1, g, 2'b00}, d, rs);
  endtask

  // execute a word, then check destination, exception reg and condition field
  task automatic ex(input logic [31:0] w, input logic [4:0] g, input logic [31:0] e,
                    input logic [31:0] x, input logic [3:0] c);
    mst_u.wr(OFS_INSTR, w, rs);
    mst_u.rd({1'b1, g, 2'b00}, rv, rs);
    chk(rv, e);
    mst_u.rd(OFS_EXC, rv, rs);
    chk(rv, x);
    mst_u.rd(OFS_CR, rv, rs);
    chk(rv, {28'h0, c});
  endtask

  // ----------------------------------------------------------------
  // clock, reset, watchdog, illegal pulse count
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // a hung handshake would otherwise stall the run forever
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (illegal_instr === 1'b1) n_ill <= n_ill + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst_b, ce, n_fail, tests_run, n_ill, cyc} = '0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    ce <= 1'b1;
    mst_u.rd(OFS_EXC, rv, rs);
    chk(rv, 32'h0000_0000);
    mst_u.rd(8'h10, rv, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    mst_u.wr(8'h81, 32'h0000_0005, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    // register zero is nonzero so the zero-field forms are told apart
    pk(5'd0, 32'h0000_0100);
    pk(5'd1, 32'hffff_ffff);
    pk(5'd2, 32'h0000_0001);
    pk(5'd6, 32'h7fff_ffff);
    ex(xw(9'h10a, 5'd3, 5'd1, 5'd2, 1'b1, 1'b1), 5'd3, 32'h0, 32'h0, 4'h2);
    ex(xw(9'h00a, 5'd4, 5'd1, 5'd2, 1'b0, 1'b0), 5'd4, 32'h0, 32'h2000_0000, 4'h2);
    ex(xw(9'h08a, 5'd5, 5'd2, 5'd2, 1'b0, 1'b0), 5'd5, 32'h3, 32'h0, 4'h2);
    ex(xw(9'h10a, 5'd7, 5'd6, 5'd2, 1'b1, 1'b1), 5'd7, 32'h8000_0000, 32'hc000_0000, 4'h9);
    ex(xw(9'h10a, 5'd8, 5'd2, 5'd2, 1'b1, 1'b0), 5'd8, 32'h2, 32'h8000_0000, 4'h9);
    ex(xw(9'h10a, 5'd8, 5'd6, 5'd2, 1'b0, 1'b1), 5'd8, 32'h8000_0000, 32'h8000_0000, 4'h9);
    ex(xw(9'h10a, 5'd8, 5'd2, 5'd2, 1'b0, 1'b1), 5'd8, 32'h2, 32'h8000_0000, 4'h5);
    ex(dw(6'h0e, 5'd9, 5'd0, 16'hffff), 5'd9, 32'hffff_ffff, 32'h8000_0000, 4'h5);
    ex(dw(6'h0c, 5'd10, 5'd1, 16'h0001), 5'd10, 32'h0, 32'ha000_0000, 4'h5);
    ex(dw(6'h0d, 5'd11, 5'd2, 16'hffff), 5'd11, 32'h0, 32'ha000_0000, 4'h3);
    ex(dw(6'h0f, 5'd12, 5'd2, 16'h1234), 5'd12, 32'h1234_0001, 32'ha000_0000, 4'h3);
    ex(dw(6'h0f, 5'd16, 5'd0, 16'h8000), 5'd16, 32'h8000_0000, 32'ha000_0000, 4'h3);
    ex(xw(9'h0ca, 5'd14, 5'd2, 5'd0, 1'b0, 1'b0), 5'd14, 32'h2, 32'h8000_0000, 4'h3);
    ex(xw(9'h0ea, 5'd13, 5'd2, 5'd0, 1'b0, 1'b1), 5'd13, 32'h0, 32'ha000_0000, 4'h3);
    ex(xw(9'h01c, 5'd1, 5'd17, 5'd12, 1'b0, 1'b1), 5'd17, 32'h1234_0001, 32'ha000_0000, 4'h5);
    ex(dw(6'h00, 5'd2, 5'd2, 16'h0001), 5'd2, 32'h1, 32'ha000_0000, 4'h5);
    ex(xw(9'h1ff, 5'd2, 5'd1, 5'd1, 1'b0, 1'b1), 5'd2, 32'h1, 32'ha000_0000, 4'h5);
    chk(n_ill, 32'h2);
    mst_u.rd(OFS_STAT, rv, rs);
    chk(rv, 32'h1);
    mst_u.wr(OFS_STAT, 32'h1, rs);
    mst_u.rd(OFS_STAT, rv, rs);
    chk(rv, 32'h0);
    end_sim();
  end
endmodule
